// ---- rtl/its_pkg.sv ----
// its_pkg: constants, register map and carrier types of the integral test sequencer.
// assumes one 125 MHz clock; all slow timing is counted in 1 ms enable ticks.
package its_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DEBOUNCE_MS   = 10;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned OHM_CLEAR_MIN = 10;
  localparam int unsigned OHM_CLEAR_MS  = OHM_CLEAR_MIN * 60 * 1000;
  localparam int unsigned REVERT_HOURS  = 3;
  localparam int unsigned REVERT_MS     = REVERT_HOURS * 3600 * 1000;
  localparam int unsigned ARC_MULT      = 5;
  localparam int unsigned GND_STEP_MS   = 100;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] ADDR_PICKUP_PHASE = 8'h00;
  localparam logic [7:0] ADDR_PICKUP_OTHER = 8'h04;
  localparam logic [7:0] ADDR_GND_TIME     = 8'h08;
  localparam logic [7:0] ADDR_STATUS       = 8'h0C;
  localparam logic [7:0] ADDR_ELAPSED      = 8'h10;

  localparam logic [31:0] RST_PICKUP_PHASE = 32'h0400_0100;
  localparam logic [31:0] RST_PICKUP_OTHER = 32'h0040_0800;
  localparam logic [7:0]  RST_GND_TIME     = 8'h01;

  // status fields
  localparam int STS_STATE_LSB = 0;
  localparam int STS_CAUSE_LSB = 4;
  localparam int STS_LEVEL_LSB = 8;
  localparam int STS_TRIP_BIT  = 12;
  localparam int STS_ARC_BIT   = 13;

  // currents are in 1/256 of rated current
  localparam logic [15:0] IN_UNIT    = 16'h0100;
  localparam logic [15:0] GND_TEST_V = 16'h0100;

  // cause indicator bit positions
  localparam int CAUSE_LD   = 0;
  localparam int CAUSE_SD   = 1;
  localparam int CAUSE_INST = 2;
  localparam int CAUSE_GND  = 3;

  typedef enum logic [2:0] {
    ITS_LVL_X1   = 3'b000,
    ITS_LVL_X2   = 3'b001,
    ITS_LVL_X3   = 3'b010,
    ITS_LVL_SIX  = 3'b011,
    ITS_LVL_X8   = 3'b100,
    ITS_LVL_X10  = 3'b101,
    ITS_LVL_GND  = 3'b110,
    ITS_LVL_GNDT = 3'b111
  } its_level_t;

  typedef enum logic [1:0] {
    ITS_ST_IDLE    = 2'b00,
    ITS_ST_RUN     = 2'b01,
    ITS_ST_DONE    = 2'b10,
    ITS_ST_TRIPPED = 2'b11
  } its_state_t;

  typedef enum logic [1:0] {
    ITS_DISP_CURRENT = 2'b00,
    ITS_DISP_ELAPSED = 2'b01,
    ITS_DISP_CODE    = 2'b10,
    ITS_DISP_TEST    = 2'b11
  } its_disp_t;

  typedef struct packed {
    logic step;
    logic trip_reset;
    logic test;
  } its_buttons_t;

  typedef struct packed {
    its_disp_t   mode;
    logic [23:0] value;
  } its_display_t;

endpackage : its_pkg

// ---- rtl/its_sequencer.sv ----
// its_sequencer: integral test sequencer with an AHB-Lite register slave.
// assumes buttons, selector and protection core signals are synchronous to hclk.
//
// Functional notes
// - levels 1,2,3,8,10 and ground never trip
// - six-times and ground trip levels trip breaker
// - start on test release; display elapsed time
// - refuse start when load above half pickup
// - abort running test when load exceeds half
// - real fault overrides test, actual settings trip
// - no-trip: timer stops, lower settings light red
// - long-delay indicator flashes while timing
// - trip reset clears indicators, shows current
// - unreset no-trip test reverts after three hours
// - trip reset release stops running test
// - trip test trips, lights cause, shows code
// - step after trip shows simulated test current
// - overload history accumulates only at six-times
// - overload history clears ten minutes after trip
// - level one test then reset clears history
// - green status blinks about once per second
// - ground arc memory stays active in tests
// - arc memory holds five times ground time
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module its_sequencer
  import its_pkg::*;
#(
  parameter int unsigned TICK_CYC   = TICK_CYCLES,
  parameter int unsigned REVERT_CNT = REVERT_MS,
  parameter int unsigned OHM_CNT    = OHM_CLEAR_MS
)(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  input  wire its_buttons_t buttons,
  input  wire logic [2:0]   test_level,
  input  wire logic [15:0]  load_current,
  input  wire logic         real_fault,
  input  wire logic         prot_operated,
  input  wire logic         ld_trip,
  input  wire logic         ground_current,
  output logic [15:0]       sim_current,
  output logic              sim_ground,
  output logic              breaker_trip,
  output logic [3:0]        cause_led,
  output logic              status_led,
  output its_display_t      display,
  output logic              overload_history_memory_accum,
  output logic              overload_history_memory_clear,
  output logic              ground_arc_memory_hold
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] its_test_value(input its_level_t lvl);
    unique case (lvl)
      ITS_LVL_X1:   its_test_value = IN_UNIT;
      ITS_LVL_X2:   its_test_value = 16'(IN_UNIT * 2);
      ITS_LVL_X3:   its_test_value = 16'(IN_UNIT * 3);
      ITS_LVL_SIX:  its_test_value = 16'(IN_UNIT * 6);
      ITS_LVL_X8:   its_test_value = 16'(IN_UNIT * 8);
      ITS_LVL_X10:  its_test_value = 16'(IN_UNIT * 10);
      ITS_LVL_GND,
      ITS_LVL_GNDT: its_test_value = GND_TEST_V;
    endcase
  endfunction : its_test_value

  function automatic logic its_trip_level(input its_level_t lvl);
    its_trip_level = (lvl == ITS_LVL_SIX) || (lvl == ITS_LVL_GNDT);
  endfunction : its_trip_level

  function automatic logic its_gnd_level(input its_level_t lvl);
    its_gnd_level = (lvl == ITS_LVL_GND) || (lvl == ITS_LVL_GNDT);
  endfunction : its_gnd_level

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [31:0] pickup_phase_r;
  logic [31:0] pickup_other_r;
  logic [7:0]  gnd_time_r;
  its_state_t  state_r;
  its_level_t  level_r;
  logic [23:0] elapsed_r;
  logic [23:0] revert_cnt_r;
  logic [23:0] ohm_cnt_r;
  logic        ohm_run_r;
  logic [16:0] arc_cnt_r;
  logic [16:0] tick_cnt_r;
  logic        tick_r;
  logic [9:0]  blink_cnt_r;
  logic        flash_r;
  logic        addr_wr_r;
  logic [7:0]  addr_r;

  logic [15:0] ld_pickup;
  logic [3:0]  would_operate;
  logic        load_high;
  logic        test_rel;
  logic        reset_rel;
  logic        step_rel;

  assign ld_pickup = pickup_phase_r[15:0];
  assign load_high = {load_current, 1'b0} > {1'b0, ld_pickup};

  // functions whose pickup is below the simulated value of the latched level
  always_comb
  begin
    would_operate = '0;
    if (its_gnd_level(level_r))
      would_operate[CAUSE_GND] = pickup_other_r[31:16] < its_test_value(level_r);
    else
    begin
      would_operate[CAUSE_LD]   = ld_pickup < its_test_value(level_r);
      would_operate[CAUSE_SD]   = pickup_phase_r[31:16] < its_test_value(level_r);
      would_operate[CAUSE_INST] = pickup_other_r[15:0] < its_test_value(level_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 1 ms tick and status blink

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_cnt_r == 17'(TICK_CYC - 1));
      if (tick_cnt_r == 17'(TICK_CYC - 1))
        tick_cnt_r <= '0;
      else
        tick_cnt_r <= tick_cnt_r + 17'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blink_cnt_r <= '0;
      flash_r     <= 1'b0;
      status_led  <= 1'b0;
    end
    else if (tick_r)
    begin
      if (blink_cnt_r == 10'(BLINK_HALF_MS - 1))
      begin
        blink_cnt_r <= '0;
        flash_r     <= ~flash_r;
        status_led  <= ~flash_r;
      end
      else
        blink_cnt_r <= blink_cnt_r + 10'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // push-button debounce; an event is the release of a stable press

  logic [2:0] btn_raw;
  logic [2:0] btn_stable_r;
  logic [2:0] btn_rel_r;
  logic [3:0] deb_cnt_r [3];

  assign btn_raw   = {buttons.step, buttons.trip_reset, buttons.test};
  assign test_rel  = btn_rel_r[0];
  assign reset_rel = btn_rel_r[1];
  assign step_rel  = btn_rel_r[2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      btn_stable_r <= '0;
      btn_rel_r    <= '0;
      for (int i = 0; i < 3; i++)
        deb_cnt_r[i] <= '0;
    end
    else
    begin
      btn_rel_r <= '0;
      for (int i = 0; i < 3; i++)
      begin
        if (btn_raw[i] == btn_stable_r[i])
          deb_cnt_r[i] <= '0;
        else if (tick_r)
        begin
          if (deb_cnt_r[i] == 4'(DEBOUNCE_MS - 1))
          begin
            btn_stable_r[i] <= btn_raw[i];
            btn_rel_r[i]    <= btn_stable_r[i];
            deb_cnt_r[i]    <= '0;
          end
          else
            deb_cnt_r[i] <= deb_cnt_r[i] + 4'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test sequence

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r      <= ITS_ST_IDLE;
      level_r      <= ITS_LVL_X1;
      elapsed_r    <= '0;
      revert_cnt_r <= '0;
      breaker_trip <= 1'b0;
      cause_led    <= '0;
    end
    else
    begin
      unique case (state_r)
        ITS_ST_IDLE:
        begin
          if (test_rel && !load_high && !real_fault)
          begin
            state_r   <= ITS_ST_RUN;
            level_r   <= its_level_t'(test_level);
            elapsed_r <= '0;
            cause_led <= '0;
          end
        end
        ITS_ST_RUN:
        begin
          if (tick_r)
            elapsed_r <= elapsed_r + 24'd1;
          cause_led[CAUSE_LD] <= would_operate[CAUSE_LD] & flash_r;
          if (load_high || real_fault || reset_rel)
          begin
            state_r   <= ITS_ST_IDLE;
            cause_led <= '0;
          end
          else if (prot_operated)
          begin
            cause_led    <= would_operate;
            revert_cnt_r <= '0;
            if (its_trip_level(level_r))
            begin
              state_r      <= ITS_ST_TRIPPED;
              breaker_trip <= 1'b1;
            end
            else
              state_r <= ITS_ST_DONE;
          end
        end
        ITS_ST_DONE:
        begin
          if (tick_r)
            revert_cnt_r <= revert_cnt_r + 24'd1;
          if (reset_rel || (revert_cnt_r >= 24'(REVERT_CNT)))
          begin
            state_r   <= ITS_ST_IDLE;
            cause_led <= '0;
          end
        end
        ITS_ST_TRIPPED:
        begin
          breaker_trip <= 1'b0;
          if (reset_rel)
          begin
            state_r   <= ITS_ST_IDLE;
            cause_led <= '0;
          end
        end
      endcase
    end
  end

  // simulated current drives the protection core only while timing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sim_current <= '0;
      sim_ground  <= 1'b0;
    end
    else
    begin
      sim_current <= (state_r == ITS_ST_RUN) ? its_test_value(level_r) : 16'h0000;
      sim_ground  <= (state_r == ITS_ST_RUN) && its_gnd_level(level_r);
    end
  end

  // display: step switches once to the simulated value, only after a trip test
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      display <= '{mode: ITS_DISP_CURRENT, value: 24'h00_0000};
    else
    begin
      unique case (state_r)
        ITS_ST_IDLE:
          display <= '{mode: ITS_DISP_CURRENT, value: {8'h00, load_current}};
        ITS_ST_RUN,
        ITS_ST_DONE:
          display <= '{mode: ITS_DISP_ELAPSED, value: elapsed_r};
        ITS_ST_TRIPPED:
        begin
          if (step_rel && display.mode == ITS_DISP_CODE)
            display <= '{mode: ITS_DISP_TEST, value: {8'h00, its_test_value(level_r)}};
          else if (display.mode != ITS_DISP_TEST)
            display <= '{mode: ITS_DISP_CODE, value: {20'h0_0000, cause_led}};
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overload history and ground arc memory control

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      overload_history_memory_accum <= 1'b0;
      overload_history_memory_clear <= 1'b0;
      ohm_run_r                     <= 1'b0;
      ohm_cnt_r                     <= '0;
    end
    else
    begin
      overload_history_memory_accum <= (state_r == ITS_ST_RUN) && (level_r == ITS_LVL_SIX);
      overload_history_memory_clear <= 1'b0;
      if (state_r == ITS_ST_RUN && level_r == ITS_LVL_X1 && reset_rel)
      begin
        overload_history_memory_clear <= 1'b1;
        ohm_run_r                     <= 1'b0;
      end
      // a long-delay trip in the same cycle still restarts the clear timer
      if (ld_trip)
      begin
        ohm_run_r <= 1'b1;
        ohm_cnt_r <= '0;
      end
      else if (ohm_run_r && tick_r)
      begin
        if (ohm_cnt_r >= 24'(OHM_CNT - 1))
        begin
          overload_history_memory_clear <= 1'b1;
          ohm_run_r                     <= 1'b0;
        end
        else
          ohm_cnt_r <= ohm_cnt_r + 24'd1;
      end
    end
  end

  // hold restarts on every ground current burst, tests included
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      arc_cnt_r              <= '0;
      ground_arc_memory_hold <= 1'b0;
    end
    else if (ground_current || sim_ground)
    begin
      arc_cnt_r              <= '0;
      ground_arc_memory_hold <= 1'b1;
    end
    else if (ground_arc_memory_hold && tick_r)
    begin
      // 17 bits so the widest time setting does not wrap the limit
      if (arc_cnt_r >= 17'(gnd_time_r * 17'(ARC_MULT * GND_STEP_MS)) - 17'd1)
        ground_arc_memory_hold <= 1'b0;
      else
        arc_cnt_r <= arc_cnt_r + 17'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  logic addr_ok;
  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_wr_r <= 1'b0;
      addr_r    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (hready)
    begin
      addr_wr_r <= addr_ok && hwrite;
      addr_r    <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pickup_phase_r <= RST_PICKUP_PHASE;
      pickup_other_r <= RST_PICKUP_OTHER;
      gnd_time_r     <= RST_GND_TIME;
    end
    else if (addr_wr_r)
    begin
      unique case (addr_r)
        ADDR_PICKUP_PHASE: pickup_phase_r <= hwdata;
        ADDR_PICKUP_OTHER: pickup_other_r <= hwdata;
        ADDR_GND_TIME:     gnd_time_r     <= hwdata[7:0];
        default:           ;
      endcase
    end
  end

  // read data is captured in the address phase, valid in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (addr_ok && !hwrite)
    begin
      unique case (haddr[7:0])
        ADDR_PICKUP_PHASE: hrdata <= pickup_phase_r;
        ADDR_PICKUP_OTHER: hrdata <= pickup_other_r;
        ADDR_GND_TIME:     hrdata <= {24'h00_0000, gnd_time_r};
        ADDR_STATUS:
        begin
          hrdata                                <= '0;
          hrdata[STS_STATE_LSB +: 2]            <= state_r;
          hrdata[STS_CAUSE_LSB +: 4]            <= cause_led;
          hrdata[STS_LEVEL_LSB +: 3]            <= level_r;
          hrdata[STS_TRIP_BIT]                  <= breaker_trip;
          hrdata[STS_ARC_BIT]                   <= ground_arc_memory_hold;
        end
        ADDR_ELAPSED:      hrdata <= {8'h00, elapsed_r};
        default:           hrdata <= '0;
      endcase
    end
  end

endmodule : its_sequencer

// ---- verification/its_core_model.sv ----
// its_core_model: protection core seen from the sequencer, answers simulated tests.
// assumes sim_current is zero whenever no test runs; lat sets how slowly it operates.
`timescale 1ns/1ps
module its_core_model
  import its_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [11:0] lat,
  input  wire logic [15:0] sim_current,
  input  wire logic        sim_ground,
  input  wire logic        breaker_trip,
  output logic             prot_operated,
  output logic             ld_trip
);
  logic [11:0] wait_r;
  logic        fired_r;
  logic        gnd_r;

  // one operate pulse per test; a new test restarts the delay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wait_r        <= '0;
      fired_r       <= 1'b0;
      prot_operated <= 1'b0;
    end
    else if (sim_current == 16'h0000)
    begin
      wait_r        <= '0;
      fired_r       <= 1'b0;
      prot_operated <= 1'b0;
    end
    else
    begin
      prot_operated <= !fired_r && wait_r == lat;
      if (wait_r == lat)
        fired_r <= 1'b1;
      else
        wait_r <= wait_r + 12'h001;
    end
  end

  // a phase trip ends in a long-delay trip, a ground trip does not
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gnd_r   <= 1'b0;
      ld_trip <= 1'b0;
    end
    else
    begin
      if (sim_current != 16'h0000)
        gnd_r <= sim_ground;
      ld_trip <= breaker_trip && !gnd_r;
    end
  end
endmodule : its_core_model

// ---- verification/its_sequencer_sva.sv ----
// its_sequencer_sva: port checks of the integral test sequencer.
// assumes the reset pickup settings stay in place during the run.
`timescale 1ns/1ps
module its_sequencer_sva
  import its_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter int unsigned OHM_CNT  = OHM_CLEAR_MS
)(
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic [15:0]  load_current,
  input wire logic         real_fault,
  input wire logic         ld_trip,
  input wire logic [15:0]  sim_current,
  input wire logic         breaker_trip,
  input wire logic [3:0]   cause_led,
  input wire logic         status_led,
  input wire its_display_t display,
  input wire logic         overload_history_memory_accum,
  input wire logic         overload_history_memory_clear
);
  localparam logic [15:0] LD_HALF = {1'b0, RST_PICKUP_PHASE[15:1]};
  localparam int HALF   = BLINK_HALF_MS * TICK_CYC;
  localparam int OHM_LO = OHM_CNT * TICK_CYC - 12;
  localparam int OHM_HI = OHM_CNT * TICK_CYC + 12;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [31:0] blink_r;
  logic        led_q_r;
  logic        seen_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blink_r <= '0;
      led_q_r <= 1'b0;
      seen_r  <= 1'b0;
    end
    else
    begin
      led_q_r <= status_led;
      blink_r <= (status_led != led_q_r) ? 32'h0000_0000 : blink_r + 32'h0000_0001;
      seen_r  <= seen_r | (status_led != led_q_r);
    end
  end

  sequence s_run_start;
    $rose(sim_current != 16'h0000);
  endsequence
  sequence s_cleared;
    sim_current == 16'h0000;
  endsequence

  a_start_load_ok: assert property (s_run_start |-> $past(load_current) <= LD_HALF && !$past(real_fault))
    else $error("test started above half pickup");
  a_abort_load: assert property (sim_current != 16'h0000 && load_current > LD_HALF |-> ##[1:3] s_cleared)
    else $error("test not aborted on high load");
  a_fault_wins: assert property (sim_current != 16'h0000 && real_fault |-> ##[1:3] s_cleared)
    else $error("test not stopped by real fault");
  a_show_elapsed: assert property (s_run_start |-> ##[0:2] display.mode == ITS_DISP_ELAPSED)
    else $error("elapsed time not shown");
  a_accum_six: assert property ($rose(overload_history_memory_accum) |-> ##[0:2] sim_current == 16'h0600)
    else $error("history accumulates off six level");
  a_ohm_clear: assert property (ld_trip |-> ##[OHM_LO:OHM_HI] overload_history_memory_clear)
    else $error("history not cleared after long delay trip");
  a_trip_code: assert property (breaker_trip |-> ##[0:2] display.mode == ITS_DISP_CODE && cause_led != 4'h0)
    else $error("trip without cause or code");
  a_trip_pulse: assert property (breaker_trip |=> !breaker_trip)
    else $error("trip pulse too long");
  a_blink_max: assert property (blink_r <= HALF + 12)
    else $error("status indicator stuck");
  a_blink_min: assert property (status_led != led_q_r && seen_r |-> blink_r >= HALF - 2)
    else $error("status indicator blinks too fast");
endmodule : its_sequencer_sva

// ---- verification/its_sequencer_bench.sv ----
// its_sequencer_bench: drives buttons, selector, load and the register bus.
// assumes shortened timing: 10-cycle tick, 50-tick revert, 20-tick history clear.
`timescale 1ns/1ps
module its_sequencer_bench
  import its_pkg::*;
;
  localparam int unsigned TICK_CYC = 10;
  localparam int unsigned OHM_CNT  = 20;
  logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, real_fault, ground_current;
  logic [31:0]  haddr, hwdata, hrdata, q;
  logic [1:0]   htrans;
  logic [2:0]   hsize, test_level;
  logic [15:0]  load_current, sim_current;
  logic [11:0]  lat;
  logic [3:0]   cause_led;
  its_buttons_t buttons;
  its_display_t display;
  logic         prot_operated, ld_trip, sim_ground, breaker_trip, status_led;
  logic         overload_history_memory_accum, overload_history_memory_clear, ground_arc_memory_hold;
  int           n_mismatch, comparisons, n_trip, n_clr, t0, c0;

  its_sequencer #(.TICK_CYC(TICK_CYC), .REVERT_CNT(50), .OHM_CNT(OHM_CNT)) DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .buttons, .test_level, .load_current, .real_fault,
    .prot_operated, .ld_trip, .ground_current, .sim_current, .sim_ground, .breaker_trip,
    .cause_led, .status_led, .display, .overload_history_memory_accum,
    .overload_history_memory_clear, .ground_arc_memory_hold);
  its_core_model u_core (.hclk, .hresetn, .lat, .sim_current, .sim_ground, .breaker_trip,
    .prot_operated, .ld_trip);

  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    n_trip += (breaker_trip === 1'b1);
    n_clr  += (overload_history_memory_clear === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // hready is this slave's own hreadyout, so waits end on it
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb
  // held well past the debounce span on both edges
  task automatic press(input int b);
    @(posedge hclk);
    buttons[b] <= 1'b1;
    repeat (150) @(posedge hclk);
    buttons[b] <= 1'b0;
    repeat (150) @(posedge hclk);
  endtask : press
  function automatic logic [15:0] tval(input logic [2:0] l);
    logic [3:0] m [8] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h8, 4'hA, 4'h1, 4'h1};
    return {4'h0, m[l], 8'h00};
  endfunction : tval
  function automatic logic [3:0] ecause(input logic [2:0] l);
    if (l[2:1] == 2'b11)
      return 4'b1000;
    return {1'b0, tval(l) > 16'h0800, tval(l) > 16'h0400, tval(l) > 16'h0100};
  endfunction : ecause
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    end_sim;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {hresetn, hsel, hwrite, real_fault, ground_current} = '0;
    {haddr, hwdata, htrans, test_level, load_current, buttons} = '0;
    hsize = 3'b010;
    lat = 12'd600;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, ADDR_PICKUP_PHASE, 0); chk(q, RST_PICKUP_PHASE);
    ahb(0, ADDR_PICKUP_OTHER, 0); chk(q, RST_PICKUP_OTHER);
    ahb(1, ADDR_GND_TIME, 32'h0000_0002);
    ahb(0, ADDR_GND_TIME, 0); chk(q, 32'h0000_0002);
    ahb(1, ADDR_GND_TIME, {24'h00_0000, RST_GND_TIME});
    ahb(1, ADDR_STATUS, 32'hFFFF_FFFF);
    ahb(0, ADDR_STATUS, 0); chk(q, 32'h0000_0000);
    ahb(0, 8'h20, 0); chk(q, 32'h0000_0000);
    $display("test registers done");
    for (int l = 0; l < 8; l++)
    begin
      t0 = n_trip;
      test_level <= 3'(l);
      press(0);
      chk(sim_current, tval(3'(l)));
      chk(display.mode, ITS_DISP_ELAPSED);
      chk({sim_ground, ground_arc_memory_hold}, {2{l >= 6}});
      test_level <= 3'(l + 1);
      repeat (600) @(posedge hclk);
      chk(cause_led, ecause(3'(l)));
      chk(n_trip - t0, (l == 3 || l == 7));
      if (l == 3 || l == 7)
      begin
        chk(display.mode, ITS_DISP_CODE);
        press(2);
        chk(display, {ITS_DISP_TEST, 8'h00, tval(3'(l))});
      end
      press(1);
      chk(cause_led, 4'h0);
      chk(display.mode, ITS_DISP_CURRENT);
    end
    $display("test levels done");
    c0 = n_clr;
    test_level <= ITS_LVL_X1;
    press(0);
    press(1);
    chk(sim_current, 16'h0000);
    chk(n_clr - c0, 1);
    $display("test history reset done");
    load_current <= 16'h0081;
    press(0);
    chk(sim_current, 16'h0000);
    load_current <= 16'h0080;
    press(0);
    chk(sim_current, tval(ITS_LVL_X1));
    load_current <= 16'h0081;
    repeat (5) @(posedge hclk);
    chk(sim_current, 16'h0000);
    load_current <= 16'h0000;
    press(0);
    real_fault <= 1'b1;
    repeat (5) @(posedge hclk);
    chk(sim_current, 16'h0000);
    real_fault <= 1'b0;
    $display("test load and fault done");
    lat <= 12'd5;
    test_level <= ITS_LVL_X2;
    press(0);
    chk(cause_led, 4'b0001);
    repeat (520) @(posedge hclk);
    chk(cause_led, 4'h0);
    chk(display.mode, ITS_DISP_CURRENT);
    $display("test revert done");
    ground_current <= 1'b1;
    repeat (20) @(posedge hclk);
    ground_current <= 1'b0;
    repeat (4900) @(posedge hclk);
    chk(ground_arc_memory_hold, 1'b1);
    repeat (200) @(posedge hclk);
    chk(ground_arc_memory_hold, 1'b0);
    $display("test arc memory done");
    end_sim;
  end
endmodule : its_sequencer_bench

bind its_sequencer its_sequencer_sva #(.TICK_CYC(TICK_CYC), .OHM_CNT(OHM_CNT)) u_sva (
  .hclk, .hresetn, .load_current, .real_fault, .ld_trip, .sim_current, .breaker_trip,
  .cause_led, .status_led, .display, .overload_history_memory_accum, .overload_history_memory_clear);
